// ### core/wpi_pkg.sv
// Shared constants and types of the wiper command interface.
// Assumes a 250 MHz core clock; the link side runs on the bus clock.
package wpi_pkg;
  localparam int CLK_MHZ   = 250;
  localparam int BYTE_W    = 8;
  localparam int ADDR_W    = 7;
  localparam int CNT_W     = 4;
  localparam int BIT_LAST  = 7;
  localparam int ACK_SLOT  = 8;
  localparam int RW_BIT    = 0;
  localparam int WP_BIT    = 0;
  localparam int CMD_LSB   = 5;
  // Link frame logic is held cleared this long after a start
  localparam int HOLD_NS   = 20;
  localparam int HOLD_CYC  = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_W    = $clog2(HOLD_CYC + 1);
  // Settling time before the address straps are caught
  localparam int STRAP_NS  = 100;
  localparam int STRAP_CYC = (STRAP_NS * CLK_MHZ + 999) / 1000;
  localparam int STRAP_W   = $clog2(STRAP_CYC + 1);
  localparam logic [6:0] ADDR_LL   = 7'h18;
  localparam logic [6:0] ADDR_HL   = 7'h1A;
  localparam logic [6:0] ADDR_LH   = 7'h4C;
  localparam logic [6:0] ADDR_HH   = 7'h4E;
  localparam logic [7:0] WIPER_RST = 8'h80;
  localparam logic [7:0] NV_RST    = 8'h80;
  localparam logic       WP_RST    = 1'h0;
  // Synchroniser lanes
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_ADL = 2;
  localparam int SY_ADH = 3;
  localparam int SY_EV  = 4;
  localparam int SY_W   = 5;
  typedef enum logic [2:0] {
    CMD_WIPER   = 3'b000,
    CMD_NV      = 3'b001,
    CMD_WP      = 3'b010,
    CMD_RSV3    = 3'b011,
    CMD_NOP     = 3'b100,
    CMD_RESTORE = 3'b101,
    CMD_STORE   = 3'b110,
    CMD_RSV7    = 3'b111
  } wpi_cmd_t;
  typedef enum logic [2:0] {
    L_ADDR  = 3'b000,
    L_INSTR = 3'b001,
    L_DATA  = 3'b010,
    L_READ  = 3'b011,
    L_SKIP  = 3'b100
  } wpi_lstate_t;
  typedef enum logic [0:0] {
    C_STRAP = 1'b0,
    C_RUN   = 1'b1
  } wpi_cstate_t;
endpackage

// ### core/wpi_link_if.sv
// Carrier between the link engine and the falling-edge data driver.
// Assumes both ends sit in the bus clock domain.
`timescale 1ns/1ps
interface wpi_link_if;
  logic oe_want;
  logic hold;
  logic sda_oe;
  modport engine (output oe_want, output hold, input sda_oe);
  modport driver (input oe_want, input hold, output sda_oe);
endinterface

// ### core/wpi_sync3.sv
// Three-stage synchroniser; a lane changes once stages two and three agree.
// Assumes asynchronous inputs and a free-running clk.
`timescale 1ns/1ps
module wpi_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import wpi_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } wpi_sync_t;

  wpi_sync_t r_r;
  wpi_sync_t r_nxt;

  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    // Hold the old value while the two late stages disagree
    r_nxt.q  = (r_r.s2 & r_r.s3) | (r_r.q & (r_r.s2 | r_r.s3));
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.q;
endmodule

// ### core/wpi_sda_drv.sv
// Falling-edge driver of the open-drain data line.
// Assumes an external pad; oe high pulls the line low.
`timescale 1ns/1ps
module wpi_sda_drv (
  input wire logic   scl_clk,
  wpi_link_if.driver lk
);
  import wpi_pkg::*;

  typedef struct packed {
    logic oe;
  } wpi_drv_t;

  wpi_drv_t d_r;
  wpi_drv_t d_nxt;

  always_comb begin
    d_nxt    = d_r;
    d_nxt.oe = lk.oe_want;
  end

  // Launch on the falling edge so the bit is settled at the rising edge
  always_ff @(negedge scl_clk or posedge lk.hold) begin
    if (lk.hold) begin
      d_r <= '0;
    end else begin
      d_r <= d_nxt;
    end
  end

  assign lk.sda_oe = d_r.oe;
endmodule

// ### core/wpi_top.sv
// Two-wire target command interface of an 8-bit wiper: address
// match, instruction decode, wiper, nonvolatile copy and write protect.
// Assumes open-drain pads outside and scl_clk wired from the bus clock pin.
`timescale 1ns/1ps
// Overview of operation
// - Four addresses chosen by two select pins
// - Frame: address, instruction, data, acks, stop
// - Command 000 targets the wiper register
// - Command 001 targets the nonvolatile copy
// - Command 010 targets write protect
// - Command 100 does nothing
// - Command 101 restores copy into wiper
// - Command 110 stores wiper into copy
// - Protect bit one enables write protect
// - Only protect bit zero releases protection
// - Protect clears on power cycle
// - Read returns a byte per controller ack, no-ack ends
// - Pointer kept, direct read allowed
// - Acknowledge by pulling data low, ninth clock
// - Select pins sampled once after power-up
// - Wiper updated by every further data byte
// - Read bits change on falling clock edge
module wpi_top (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic                         scl_clk,
  input  wire logic                         sda_i,
  output logic                              sda_o,
  output logic                              sda_oe,
  input  wire logic                         addr_select_pin_low,
  input  wire logic                         addr_select_pin_high,
  output logic [wpi_pkg::BYTE_W-1:0]        wiper_register,
  output logic [wpi_pkg::BYTE_W-1:0]        nonvolatile_wiper_copy,
  output logic                              write_protect
);
  import wpi_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    wpi_cstate_t          st;
    logic [STRAP_W-1:0]   strap_cnt;
    logic [ADDR_W-1:0]    dev_addr;
    logic                 addr_ok;
    logic                 scl_q;
    logic                 sda_q;
    logic                 busy;
    logic [HOLD_W-1:0]    hold_cnt;
    logic                 link_hold;
    logic                 ev_q;
    logic [BYTE_W-1:0]    wiper;
    logic [BYTE_W-1:0]    nv;
    logic                 wp;
    logic                 sda_o;
  } wpi_core_t;

  typedef struct packed {
    wpi_lstate_t          st;
    wpi_lstate_t          after;
    logic [CNT_W-1:0]     cnt;
    logic [BYTE_W-2:0]    sh;
    logic                 ack;
    wpi_cmd_t             cmd;
    logic [BYTE_W-1:0]    tx;
  } wpi_frame_t;

  typedef struct packed {
    logic                 ptr_nv;
    logic                 ev_tog;
    wpi_cmd_t             ev_kind;
    logic [BYTE_W-1:0]    ev_data;
    logic [ADDR_W-1:0]    dev1;
    logic [ADDR_W-1:0]    dev2;
    logic                 ok1;
    logic                 ok2;
    logic [BYTE_W-1:0]    wip1;
    logic [BYTE_W-1:0]    wip2;
    logic [BYTE_W-1:0]    nv1;
    logic [BYTE_W-1:0]    nv2;
  } wpi_persist_t;

  localparam wpi_core_t CORE_RST = '{
    st:        C_STRAP,
    link_hold: 1'b1,
    wiper:     WIPER_RST,
    nv:        NV_RST,
    wp:        WP_RST,
    default:   '0
  };

  localparam wpi_frame_t FRAME_RST = '{
    st:      L_ADDR,
    after:   L_ADDR,
    cmd:     CMD_NOP,
    default: '0
  };

  localparam wpi_persist_t PERSIST_RST = '{
    ev_kind: CMD_NOP,
    wip1:    WIPER_RST,
    wip2:    WIPER_RST,
    nv1:     NV_RST,
    nv2:     NV_RST,
    default: '0
  };

  wpi_core_t         c_r;
  wpi_core_t         c_nxt;
  wpi_frame_t        f_r;
  wpi_frame_t        f_nxt;
  wpi_persist_t      p_r;
  wpi_persist_t      p_nxt;
  logic [SY_W-1:0]   sy_in;
  logic [SY_W-1:0]   sy_q;
  logic [BYTE_W-1:0] byte_in;
  logic              scl_s;
  logic              sda_s;
  logic              start_det;
  logic              stop_det;
  logic              ev_fire;
  logic              post;
  logic              hold;

  wpi_link_if lk ();

  // ==========================================================
  // Crossings into the core clock
  assign sy_in[SY_SCL] = scl_clk;
  assign sy_in[SY_SDA] = sda_i;
  assign sy_in[SY_ADL] = addr_select_pin_low;
  assign sy_in[SY_ADH] = addr_select_pin_high;
  assign sy_in[SY_EV]  = p_r.ev_tog;

  wpi_sync3 #(
    .W (SY_W)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     (sy_in),
    .q     (sy_q)
  );

  wpi_sda_drv u_drv (
    .scl_clk (scl_clk),
    .lk      (lk)
  );

  assign scl_s     = sy_q[SY_SCL];
  assign sda_s     = sy_q[SY_SDA];
  assign start_det = scl_s && c_r.scl_q && c_r.sda_q && !sda_s;
  assign stop_det  = scl_s && c_r.scl_q && !c_r.sda_q && sda_s;
  // Payload is stable by the time its toggle has crossed
  assign ev_fire   = sy_q[SY_EV] ^ c_r.ev_q;
  assign byte_in   = {f_r.sh, sda_i};
  assign hold      = c_r.link_hold;
  assign lk.hold   = hold;
  // Open drain: pull low for an acknowledge or a zero read bit
  assign lk.oe_want = (f_r.cnt == CNT_W'(ACK_SLOT) && f_r.ack) ||
                      (f_r.st == L_READ && f_r.cnt != CNT_W'(ACK_SLOT) && !f_r.tx[BYTE_W-1]);

  // ==========================================================
  // Next state
  always_comb begin
    c_nxt = c_r;
    f_nxt = f_r;
    p_nxt = p_r;
    post  = 1'b0;

    c_nxt.scl_q = scl_s;
    c_nxt.sda_q = sda_s;
    c_nxt.ev_q  = sy_q[SY_EV];
    c_nxt.sda_o = 1'b0;

    // Straps are caught once, after the synchroniser has settled
    case (c_r.st)
      C_STRAP: begin
        if (c_r.strap_cnt == STRAP_W'(STRAP_CYC - 1)) begin
          c_nxt.st      = C_RUN;
          c_nxt.addr_ok = 1'b1;
          case ({sy_q[SY_ADH], sy_q[SY_ADL]})
            2'h0: begin
              c_nxt.dev_addr = ADDR_LL;
            end
            2'h2: begin
              c_nxt.dev_addr = ADDR_HL;
            end
            2'h1: begin
              c_nxt.dev_addr = ADDR_LH;
            end
            default: begin
              c_nxt.dev_addr = ADDR_HH;
            end
          endcase
        end else begin
          c_nxt.strap_cnt = c_r.strap_cnt + 1'b1;
        end
      end
      C_RUN: begin
      end
      default: begin
        c_nxt.st = C_STRAP;
      end
    endcase

    // A start (or repeated start) clears the frame engine briefly
    if (start_det) begin
      c_nxt.busy     = 1'b1;
      c_nxt.hold_cnt = HOLD_W'(HOLD_CYC);
    end else if (stop_det) begin
      c_nxt.busy = 1'b0;
    end else if (c_r.hold_cnt != '0) begin
      c_nxt.hold_cnt = c_r.hold_cnt - 1'b1;
    end
    c_nxt.link_hold = !c_nxt.busy || (c_nxt.hold_cnt != '0);

    if (ev_fire) begin
      case (p_r.ev_kind)
        CMD_WIPER: begin
          if (!c_r.wp) begin
            c_nxt.wiper = p_r.ev_data;
          end
        end
        CMD_NV: begin
          if (!c_r.wp) begin
            c_nxt.nv = p_r.ev_data;
          end
        end
        CMD_WP: begin
          c_nxt.wp = p_r.ev_data[WP_BIT];
        end
        CMD_RESTORE: begin
          c_nxt.wiper = c_r.nv;
        end
        CMD_STORE: begin
          if (!c_r.wp) begin
            c_nxt.nv = c_r.wiper;
          end
        end
        default: begin
        end
      endcase
    end

    // Link side: quasi-static values pass two bus-clock stages
    p_nxt.dev1 = c_r.dev_addr;
    p_nxt.dev2 = p_r.dev1;
    p_nxt.ok1  = c_r.addr_ok;
    p_nxt.ok2  = p_r.ok1;
    p_nxt.wip1 = c_r.wiper;
    p_nxt.wip2 = p_r.wip1;
    p_nxt.nv1  = c_r.nv;
    p_nxt.nv2  = p_r.nv1;

    if (f_r.cnt != CNT_W'(ACK_SLOT)) begin
      f_nxt.cnt = f_r.cnt + 1'b1;
      f_nxt.sh  = byte_in[BYTE_W-2:0];
      if (f_r.st == L_READ) begin
        f_nxt.tx = {f_r.tx[BYTE_W-2:0], 1'b0};
      end
      if (f_r.cnt == CNT_W'(BIT_LAST)) begin
        f_nxt.ack = 1'b1;
        case (f_r.st)
          L_ADDR: begin
            if (p_r.ok2 && byte_in[BYTE_W-1:1] == p_r.dev2) begin
              f_nxt.after = byte_in[RW_BIT] ? L_READ : L_INSTR;
            end else begin
              f_nxt.ack   = 1'b0;
              f_nxt.after = L_SKIP;
            end
          end
          L_INSTR: begin
            f_nxt.cmd   = wpi_cmd_t'(byte_in[BYTE_W-1:CMD_LSB]);
            f_nxt.after = L_DATA;
            case (f_nxt.cmd)
              CMD_WIPER: begin
                p_nxt.ptr_nv = 1'b0;
              end
              CMD_NV: begin
                p_nxt.ptr_nv = 1'b1;
              end
              CMD_RESTORE, CMD_STORE: begin
                post          = 1'b1;
                p_nxt.ev_kind = f_nxt.cmd;
              end
              default: begin
              end
            endcase
          end
          L_DATA: begin
            f_nxt.after = L_DATA;
            // Repeated data bytes keep writing until the stop
            if (f_r.cmd inside {CMD_WIPER, CMD_NV, CMD_WP}) begin
              post          = 1'b1;
              p_nxt.ev_kind = f_r.cmd;
            end
          end
          L_READ: begin
            f_nxt.ack   = 1'b0;
            f_nxt.after = L_READ;
          end
          default: begin
            f_nxt.ack   = 1'b0;
            f_nxt.after = L_SKIP;
          end
        endcase
      end
    end else begin
      f_nxt.cnt = '0;
      f_nxt.ack = 1'b0;
      f_nxt.st  = f_r.after;
      if (f_r.after == L_READ) begin
        // Controller no-acknowledge ends the read
        if (f_r.st == L_READ && sda_i) begin
          f_nxt.st = L_SKIP;
        end else begin
          f_nxt.tx = p_r.ptr_nv ? p_r.nv2 : p_r.wip2;
        end
      end
    end

    if (post) begin
      p_nxt.ev_tog  = !p_r.ev_tog;
      p_nxt.ev_data = byte_in;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c_r <= CORE_RST;
    end else begin
      c_r <= c_nxt;
    end
  end

  // Frame state never outlives its frame: cleared between frames
  always_ff @(posedge scl_clk or posedge hold) begin
    if (hold) begin
      f_r <= FRAME_RST;
    end else begin
      f_r <= f_nxt;
    end
  end

  always_ff @(posedge scl_clk or posedge reset) begin
    if (reset) begin
      p_r <= PERSIST_RST;
    end else begin
      p_r <= p_nxt;
    end
  end

  assign sda_o                  = c_r.sda_o;
  assign sda_oe                 = lk.sda_oe;
  assign wiper_register         = c_r.wiper;
  assign nonvolatile_wiper_copy = c_r.nv;
  assign write_protect          = c_r.wp;

  // ==========================================================
  // Checks
  a_wiper_write:
    assert property (@(posedge clk) disable iff (reset)
      ev_fire && p_r.ev_kind == CMD_WIPER && !c_r.wp |=> c_r.wiper == $past(p_r.ev_data))
    else $error("wiper write not applied");

  a_nv_write:
    assert property (@(posedge clk) disable iff (reset)
      ev_fire && p_r.ev_kind == CMD_NV && !c_r.wp |=> c_r.nv == $past(p_r.ev_data))
    else $error("copy write not applied");

  a_restore_copy:
    assert property (@(posedge clk) disable iff (reset)
      ev_fire && p_r.ev_kind == CMD_RESTORE |=> c_r.wiper == $past(c_r.nv))
    else $error("restore did not copy");

  a_store_copy:
    assert property (@(posedge clk) disable iff (reset)
      ev_fire && p_r.ev_kind == CMD_STORE && !c_r.wp |=> c_r.nv == $past(c_r.wiper))
    else $error("store did not copy");

  a_wp_set:
    assert property (@(posedge clk) disable iff (reset)
      ev_fire && p_r.ev_kind == CMD_WP && p_r.ev_data[WP_BIT] |=> c_r.wp ##1 c_r.wp)
    else $error("protect not entered");

  a_wp_keep:
    assert property (@(posedge clk) disable iff (reset)
      c_r.wp && !(ev_fire && p_r.ev_kind == CMD_WP) |=> c_r.wp)
    else $error("protect released without command");

  a_wp_power:
    assert property (@(posedge clk) disable iff (reset)
      $fell(reset) |-> !c_r.wp && c_r.wiper == WIPER_RST)
    else $error("protect set after reset");

  a_strap_once:
    assert property (@(posedge clk) disable iff (reset)
      c_r.st == C_RUN |=> c_r.st == C_RUN && $stable(c_r.dev_addr))
    else $error("address changed after strap");

  a_addr_ack:
    assert property (@(posedge scl_clk) disable iff (hold)
      f_r.st == L_ADDR && f_r.cnt == CNT_W'(BIT_LAST) && p_r.ok2 && byte_in[BYTE_W-1:1] == p_r.dev2
      |=> f_r.ack && lk.oe_want ##1 f_r.cnt == '0 && !f_r.ack)
    else $error("own address not acknowledged");

  a_nop_quiet:
    assert property (@(posedge scl_clk) disable iff (hold)
      f_r.st == L_INSTR && f_r.cnt == CNT_W'(BIT_LAST) && byte_in[BYTE_W-1:CMD_LSB] inside {3'h3, 3'h4, 3'h7}
      |=> $stable(p_r.ev_tog))
    else $error("no-op command posted an event");

  a_read_shift:
    assert property (@(posedge scl_clk) disable iff (hold)
      f_r.st == L_READ && f_r.cnt < CNT_W'(BIT_LAST) |=> f_r.tx[BYTE_W-1:1] == $past(f_r.tx[BYTE_W-2:0]))
    else $error("read byte not shifted");
endmodule

// ### verification/wpi_ctrl_model.sv
// Two-wire bus controller model: start, repeated start, stop and byte transfers.
// Assumes a pull-up on the data line; tasks are entered at a core clock falling edge.
`timescale 1ns/1ps
module wpi_ctrl_model #(
  parameter int Q = 40
) (
  output logic      scl,
  output logic      pull,
  input  wire logic sda
);
  // Clock stands high between frames
  initial begin
    scl  = 1'b1;
    pull = 1'b0;
  end
  // ==========================================
  // Conditions
  task automatic start();
    pull = 1'b1;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask
  task automatic rstart();
    pull = 1'b0;
    #Q scl = 1'b1;
    #Q pull = 1'b1;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    pull = 1'b1;
    #Q scl = 1'b1;
    #Q pull = 1'b0;
    #(2*Q);
  endtask
  // ==========================================
  // Bits and bytes
  // Data changes a quarter bit after the falling edge, sampled mid-high
  task automatic pulse(output logic lvl);
    #Q scl = 1'b1;
    #Q lvl = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack_n);
    logic lvl;
    for (int i = 7; i >= 0; i--) begin
      pull = ~b[i];
      pulse(lvl);
    end
    pull = 1'b0;
    pulse(ack_n);
  endtask
  task automatic rbyte(input logic more, output logic [7:0] b);
    logic lvl;
    pull = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(lvl);
      b[i] = lvl;
    end
    pull = more;
    pulse(lvl);
    pull = 1'b0;
  endtask
endmodule

// ### verification/wpi_top_tb.sv
// Self-checking bench of the wiper command interface.
// Assumes the controller model on the bus and a pull-up on the data line.
`timescale 1ns/1ps
module wpi_top_tb;
  import wpi_pkg::*;
  localparam int LIMIT = 60000;
  logic       clk;
  logic       reset;
  logic       pull;
  logic       scl;
  logic       sda;
  logic       sda_o;
  logic       sda_oe;
  logic       addr_lo;
  logic       addr_hi;
  logic [7:0] wiper;
  logic [7:0] nvc;
  logic       wp;
  logic [6:0] dev;
  int         n_errors = 0;
  int         total_checks = 0;
  int         cycles = 0;
  // Open drain: either party pulls low, else the pull-up wins
  assign sda = (pull | sda_oe) ? 1'b0 : 1'b1;
  wpi_ctrl_model m (.scl(scl), .pull(pull), .sda(sda));
  wpi_top dut (.clk(clk), .reset(reset), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_select_pin_low(addr_lo), .addr_select_pin_high(addr_hi), .wiper_register(wiper),
    .nonvolatile_wiper_copy(nvc), .write_protect(wp));
  initial clk = 1'b0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      complete_run();
    end
  end
  // ==========================================
  // Compare and report
  task automatic check_bit(input logic got, input logic exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // Frames
  task automatic do_reset(input logic hi, input logic lo);
    @(negedge clk);
    addr_hi = hi;
    addr_lo = lo;
    reset = 1'b1;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (50) @(negedge clk);
  endtask
  task automatic probe(input logic [6:0] a7, input logic exp_n);
    logic a;
    m.start();
    m.wbyte({a7, 1'b0}, a);
    m.stop();
    check_bit(a, exp_n, "address answer");
  endtask
  task automatic wr_frame(input logic [7:0] ins, input int n, input logic [7:0] d0, input logic [7:0] d1);
    logic a;
    m.start();
    m.wbyte({dev, 1'b0}, a);
    check_bit(a, 1'b0, "address ack");
    m.wbyte(ins, a);
    check_bit(a, 1'b0, "instruction ack");
    for (int k = 0; k < n; k++) begin
      m.wbyte(k == 0 ? d0 : d1, a);
      check_bit(a, 1'b0, "data ack");
    end
    m.stop();
    repeat (10) @(negedge clk);
  endtask
  task automatic rd_frame(input logic dummy, input logic [7:0] ins, input logic [7:0] exp);
    logic       a;
    logic [7:0] b;
    m.start();
    if (dummy) begin
      m.wbyte({dev, 1'b0}, a);
      m.wbyte(ins, a);
      m.rstart();
    end
    m.wbyte({dev, 1'b1}, a);
    check_bit(a, 1'b0, "read address ack");
    m.rbyte(1'b0, b);
    m.stop();
    check_byte(b, exp, "read back");
    repeat (10) @(negedge clk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_addr();
    logic [6:0] tbl [4];
    tbl = '{7'h18, 7'h1A, 7'h4C, 7'h4E};
    for (int i = 0; i < 4; i++) begin
      do_reset(i[0], i[1]);
      check_byte(wiper, 8'h80, "wiper after reset");
      check_byte(nvc, 8'h80, "copy after reset");
      check_bit(wp, 1'b0, "protect after reset");
      check_bit(sda_o, 1'b0, "data output level");
      dev = tbl[i];
      probe(tbl[i] ^ 7'h02, 1'b1);
      probe(tbl[i], 1'b0);
    end
    @(negedge clk);
    addr_hi = 1'b0;
    addr_lo = 1'b0;
    repeat (50) @(negedge clk);
    probe(7'h4E, 1'b0);
    probe(7'h18, 1'b1);
  endtask
  task automatic t_data();
    wr_frame(8'h00, 2, 8'hA5, 8'h3C);
    check_byte(wiper, 8'h3C, "wiper after repeated write");
    check_byte(nvc, 8'h80, "copy untouched");
    wr_frame(8'h20, 1, 8'h5A, 8'h00);
    check_byte(nvc, 8'h5A, "copy write");
    rd_frame(1'b0, 8'h00, 8'h5A);
    rd_frame(1'b1, 8'h00, 8'h3C);
    rd_frame(1'b1, 8'h20, 8'h5A);
  endtask
  task automatic t_store();
    wr_frame(8'h00, 1, 8'h11, 8'h00);
    wr_frame(8'hC0, 0, 8'h00, 8'h00);
    check_byte(nvc, 8'h11, "store");
    wr_frame(8'h00, 1, 8'h22, 8'h00);
    wr_frame(8'hA0, 0, 8'h00, 8'h00);
    check_byte(wiper, 8'h11, "restore");
  endtask
  task automatic t_nop();
    logic [7:0] codes [3];
    codes = '{8'h80, 8'h60, 8'hE0};
    for (int i = 0; i < 3; i++) begin
      wr_frame(codes[i], 1, 8'hFF, 8'h00);
      check_byte(wiper, 8'h11, "wiper after idle code");
      check_byte(nvc, 8'h11, "copy after idle code");
      check_bit(wp, 1'b0, "protect after idle code");
    end
  endtask
  task automatic t_protect();
    wr_frame(8'h40, 1, 8'h01, 8'h00);
    check_bit(wp, 1'b1, "protect set");
    wr_frame(8'h00, 1, 8'h99, 8'h00);
    check_byte(wiper, 8'h11, "wiper held while protected");
    check_bit(wp, 1'b1, "protect kept");
    wr_frame(8'h40, 1, 8'h00, 8'h00);
    check_bit(wp, 1'b0, "protect released");
    wr_frame(8'h40, 1, 8'h01, 8'h00);
    do_reset(1'b1, 1'b1);
    check_bit(wp, 1'b0, "protect after power cycle");
  endtask
  initial begin
    reset = 1'b1;
    addr_hi = 1'b0;
    addr_lo = 1'b0;
    dev = 7'h18;
    t_addr();
    t_data();
    t_store();
    t_nop();
    t_protect();
    complete_run();
  end
endmodule
